// file: cmd_panel.sv
// Far-side command panel: start, stop and shutoff switches and a contactor.
`default_nettype none
module cmd_panel
  import motor_ss_pkg::*;
#(
  parameter int WAIT_CYC = 4400
) (
  input  wire logic  core_clk,
  input  wire pins_t want,
  output var pins_t  pins,
  output logic       output_contactor
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // Switches change on the clock. A start press is a whole on-then-off
  // pulse, so a turn-round is one press of the opposite input.
  always @(posedge core_clk) pins <= want;
  // The contactor opens only once the longest flux decay has run out.
  always @(posedge core_clk) begin
    cnt <= want.gp[1] ? cnt + 1 : 0;
    output_contactor <= want.gp[1] && (cnt >= WAIT_CYC);
  end
endmodule
`default_nettype wire

// file: motor_ss_pkg.sv
// Constants, types and register map of the motor start/stop control block.
`default_nettype none
package motor_ss_pkg;
  // Stop-selection codes and ranges (decimal values in hex).
  localparam logic [15:0] SEL_DECEL  = 16'h270f; // 9999
  localparam logic [15:0] SEL_RUNDIR = 16'h22b8; // 8888
  localparam logic [15:0] COAST_MAX  = 16'h0064; // 100 s
  localparam logic [15:0] OFS_LO     = 16'h03e8; // 1000
  localparam logic [15:0] OFS_HI     = 16'h044c; // 1100
  // Input terminal function codes.
  localparam logic [7:0]  FN_STOP    = 8'h19;    // 25
  localparam logic [7:0]  FN_FLUX    = 8'h4a;    // 74
  // Register byte addresses.
  localparam logic [7:0]  ADDR_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_TERM  = 8'h04;
  localparam logic [7:0]  ADDR_STAT  = 8'h08;
  // Control register fields and reset values.
  localparam int          CTRL_SEL_LSB = 0;
  localparam int          CTRL_SVC_BIT = 16;
  localparam int          CTRL_CAP_LSB = 17;
  localparam int          CTRL_JOG_BIT = 20;
  localparam logic [31:0] CTRL_RESET   = 32'h0000270f;
  localparam logic [31:0] TERM_RESET   = 32'h00000000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_DECERR  = 2'h3;
  // Timing: one millisecond of the 50 MHz core clock.
  localparam int          CLK_HZ       = 50000000;
  localparam int          TICK_MS      = 1;
  localparam int          MS_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam logic [16:0] MS_PER_S     = 17'h003e8;
  // Longest flux decay per motor capacity class, in ms.
  localparam logic [10:0] DECAY_C0 = 11'h0fa; // 250
  localparam logic [10:0] DECAY_C1 = 11'h1f4; // 500
  localparam logic [10:0] DECAY_C2 = 11'h320; // 800
  localparam logic [10:0] DECAY_C3 = 11'h384; // 900
  localparam logic [10:0] DECAY_C4 = 11'h44c; // 1100

  typedef struct packed {
    logic       fwd;
    logic       rev;
    logic       stop_term;
    logic       jog;
    logic       out_stop;
    logic [1:0] gp;
    logic       fault;
    logic       dip_restart;
    logic       tuning;
  } pins_t;

  typedef struct packed {
    logic run_fwd;
    logic run_rev;
    logic decel;
    logic coast;
    logic gate_on;
    logic decaying;
  } drive_t;

  typedef enum logic [1:0] {M_IDLE, M_RUN, M_DECEL, M_COAST} motor_t;
  typedef enum logic [1:0] {S_ON, S_DECAY, S_CUT} shut_t;
endpackage
`default_nettype wire

// file: motor_start_stop_control.sv
// Start/stop command decoding, stop method and flux-decay output shutoff.
//
// Function
// - 9999 setting decelerates when start removed.
// - 0-100 s setting coasts after set time.
// - 1000-1100 setting coasts after value minus 1000.
// - Two-wire: forward alone forward, reverse alone reverse.
// - Two-wire: both off or on decelerates.
// - 8888/1000-1100: run input plus direction input.
// - Self-hold only while stop input on.
// - Pulsed start is latched, motor keeps running.
// - Stop input off clears latch, decelerates.
// - Enabled jog input makes stop input ignored.
// - Output-stop input keeps the self-hold latch.
// - Code 25 routes stop to a terminal.
// - Code 74 routes flux shutoff to terminal.
// - Sensorless: decay flux, then cut, bounded time.
// - Other control methods cut output at once.
// - Dip restart or tuning cuts at once.
// - Other shutoff cause abandons decay immediately.
// - Output voltage stays on during flux decay.
`default_nettype none
module motor_start_stop_control
  import motor_ss_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        forward_start_input,
  input  wire logic        reverse_start_input,
  input  wire logic        stop_terminal,
  input  wire logic        jog_input,
  input  wire logic        output_stop_input,
  input  wire logic [1:0]  gp_terminal,
  input  wire logic        fault_input,
  input  wire logic        dip_restart_input,
  input  wire logic        online_tuning_input,
  output logic             run_forward,
  output logic             run_reverse,
  output logic             decel_stop,
  output logic             coast_stop,
  output logic             output_gate_on,
  output logic             flux_decay_active,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////
  // Functions.

  // Byte-lane merge of a write into a register.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // True when any general terminal assigned the given function code is on.
  function automatic logic fn_hit(input logic [15:0] term,
                                  input logic [1:0]  gp,
                                  input logic [7:0]  code);
    logic h;
    h = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (term[i*8 +: 8] == code && gp[i]) begin
        h = 1'b1;
      end
    end
    return h;
  endfunction

  // True when any general terminal is assigned the given function code.
  function automatic logic fn_used(input logic [15:0] term,
                                   input logic [7:0]  code);
    return term[7:0] == code || term[15:8] == code;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers and previous samples for edge detection.

  pins_t raw;
  pins_t meta_q;
  pins_t pin_q;
  pins_t prev_q;

  assign raw = '{fwd: forward_start_input, rev: reverse_start_input,
                 stop_term: stop_terminal, jog: jog_input,
                 out_stop: output_stop_input, gp: gp_terminal,
                 fault: fault_input, dip_restart: dip_restart_input,
                 tuning: online_tuning_input};

  // Two stages before any logic, one more stage to see edges.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      pin_q  <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= raw;
      pin_q  <= meta_q;
      prev_q <= pin_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file and AXI4-Lite slave.

  logic [31:0] ctrl_q, next_ctrl;
  logic [31:0] term_q, next_term;
  logic        aw_full, next_aw_full;
  logic        w_full, next_w_full;
  logic [7:0]  waddr_q, next_waddr;
  logic [31:0] wdata_q, next_wdata;
  logic [3:0]  wstrb_q, next_wstrb;
  logic        bvalid_q, next_bvalid;
  logic [1:0]  bresp_q, next_bresp;
  logic        awrdy_q, next_awrdy;
  logic        wrdy_q, next_wrdy;
  logic        arrdy_q, next_arrdy;
  logic        rvalid_q, next_rvalid;
  logic [31:0] rdata_q, next_rdata;
  logic [1:0]  rresp_q, next_rresp;
  logic [31:0] stat;

  // Write channels are taken independently; the write lands when both
  // halves are held, and the response waits for bready.
  always_comb begin
    next_ctrl    = ctrl_q;
    next_term    = term_q;
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_waddr   = waddr_q;
    next_wdata   = wdata_q;
    next_wstrb   = wstrb_q;
    next_bvalid  = bvalid_q;
    next_bresp   = bresp_q;
    if (s_axi_awvalid && awrdy_q) begin
      next_aw_full = 1'b1;
      next_waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wrdy_q) begin
      next_w_full = 1'b1;
      next_wdata  = s_axi_wdata;
      next_wstrb  = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_full && w_full && !bvalid_q) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      if (waddr_q == ADDR_CTRL) begin
        next_ctrl = merge(ctrl_q, wdata_q, wstrb_q);
      end else if (waddr_q == ADDR_TERM) begin
        next_term = merge(term_q, wdata_q, wstrb_q);
      end else if (waddr_q != ADDR_STAT) begin
        next_bresp = RESP_DECERR;
      end
    end
    next_awrdy = !next_aw_full;
    next_wrdy  = !next_w_full;
  end

  // Read channel: one read in flight, address taken only when idle.
  always_comb begin
    next_rvalid = rvalid_q;
    next_rdata  = rdata_q;
    next_rresp  = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arrdy_q) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      if (s_axi_araddr == ADDR_CTRL) begin
        next_rdata = ctrl_q;
      end else if (s_axi_araddr == ADDR_TERM) begin
        next_rdata = term_q;
      end else if (s_axi_araddr == ADDR_STAT) begin
        next_rdata = stat;
      end else begin
        next_rdata = 32'h0;
        next_rresp = RESP_DECERR;
      end
    end
    next_arrdy = !next_rvalid;
  end

  // Bus registers.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_q   <= CTRL_RESET;
      term_q   <= TERM_RESET;
      aw_full  <= 1'b0;
      w_full   <= 1'b0;
      waddr_q  <= 8'h00;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      awrdy_q  <= 1'b1;
      wrdy_q   <= 1'b1;
      arrdy_q  <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= RESP_OKAY;
    end else begin
      ctrl_q   <= next_ctrl;
      term_q   <= next_term;
      aw_full  <= next_aw_full;
      w_full   <= next_w_full;
      waddr_q  <= next_waddr;
      wdata_q  <= next_wdata;
      wstrb_q  <= next_wstrb;
      bvalid_q <= next_bvalid;
      bresp_q  <= next_bresp;
      awrdy_q  <= next_awrdy;
      wrdy_q   <= next_wrdy;
      arrdy_q  <= next_arrdy;
      rvalid_q <= next_rvalid;
      rdata_q  <= next_rdata;
      rresp_q  <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode.

  logic [15:0] sel;
  logic        svc;
  logic [2:0]  cap;
  logic        jog_en;
  logic        in_ofs;
  logic        mode3;
  logic        timed;
  logic [16:0] lim_ms;
  logic        stop_sig;
  logic        flux_sig;
  logic        hold_en;
  logic        want_f;
  logic        want_r;
  logic        fall_f;
  logic        fall_r;
  logic        other_cut;
  logic [10:0] decay_lim;

  assign sel    = ctrl_q[CTRL_SEL_LSB +: 16];
  assign svc    = ctrl_q[CTRL_SVC_BIT];
  assign cap    = ctrl_q[CTRL_CAP_LSB +: 3];
  assign jog_en = ctrl_q[CTRL_JOG_BIT];
  assign in_ofs = sel >= OFS_LO && sel <= OFS_HI;
  assign mode3  = sel == SEL_RUNDIR || in_ofs;
  assign timed  = sel <= COAST_MAX || in_ofs;
  // Coast delay in ms; offset settings drop the 1000.
  assign lim_ms = 17'(in_ofs ? sel - OFS_LO : sel) * MS_PER_S;

  // A terminal coded for stop takes the function off the default pin.
  assign stop_sig = fn_used(term_q[15:0], FN_STOP)
                  ? fn_hit(term_q[15:0], pin_q.gp, FN_STOP)
                  : pin_q.stop_term;
  assign flux_sig = fn_hit(term_q[15:0], pin_q.gp, FN_FLUX);
  // Stop input enables holding unless an enabled jog overrides it.
  assign hold_en  = stop_sig && !(pin_q.jog && jog_en);

  // Two-wire: each input its own direction; run/direction otherwise.
  assign want_f = pin_q.fwd && !pin_q.rev;
  assign want_r = mode3 ? pin_q.fwd && pin_q.rev
                        : pin_q.rev && !pin_q.fwd;
  assign fall_f = prev_q.fwd && !pin_q.fwd;
  assign fall_r = prev_q.rev && !pin_q.rev;
  assign other_cut = pin_q.out_stop || pin_q.fault;

  always_comb begin
    case (cap)
      3'h0:    decay_lim = DECAY_C0;
      3'h1:    decay_lim = DECAY_C1;
      3'h2:    decay_lim = DECAY_C2;
      3'h3:    decay_lim = DECAY_C3;
      default: decay_lim = DECAY_C4;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick, free running; timers see up to 1 ms of phase.

  logic [31:0] pre_q, next_pre;
  logic        tick;

  assign tick = pre_q == 32'(MS_CYC - 1);

  always_comb begin
    next_pre = tick ? 32'h0 : pre_q + 32'h1;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pre_q <= 32'h0;
    end else begin
      pre_q <= next_pre;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Self-hold latch and motor state.

  logic        hold_q, next_hold;
  logic        hrev_q, next_hrev;
  motor_t      mst_q, next_mst;
  logic        dir_q, next_dir;
  logic [16:0] mcnt_q, next_mcnt;
  logic        cmd_on;
  logic        cmd_rev;

  // The latch clears only when hold_en drops (stop input off or enabled jog on); output stop leaves it.
  always_comb begin
    next_hold = hold_q;
    next_hrev = hrev_q;
    if (!hold_en) begin
      next_hold = 1'b0;
    end else if (mode3) begin
      if (fall_f) begin
        next_hold = 1'b1;
      end
    end else if (fall_f) begin
      next_hold = 1'b1;
      next_hrev = 1'b0;
    end else if (fall_r) begin
      next_hold = 1'b1;
      next_hrev = 1'b1;
    end
  end

  // Live command wins; a held start keeps running after release.
  always_comb begin
    cmd_on  = want_f || want_r || (hold_en && hold_q);
    cmd_rev = (want_f || want_r) ? want_r
            : (mode3 ? pin_q.rev : hrev_q);
    next_mst  = mst_q;
    next_dir  = dir_q;
    next_mcnt = mcnt_q;
    if (cmd_on) begin
      next_mst  = M_RUN;
      next_dir  = cmd_rev;
      next_mcnt = 17'h0;
    end else begin
      case (mst_q)
        M_RUN: begin
          next_mst  = M_DECEL;
          next_mcnt = 17'h0;
        end
        M_DECEL: begin
          // Strictly more ticks than the delay guarantees the full time.
          if (timed && mcnt_q > lim_ms) begin
            next_mst = M_COAST;
          end else if (tick && timed) begin
            next_mcnt = mcnt_q + 17'h1;
          end
        end
        default: next_mst = mst_q;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hold_q <= 1'b0;
      hrev_q <= 1'b0;
      mst_q  <= M_IDLE;
      dir_q  <= 1'b0;
      mcnt_q <= 17'h0;
    end else begin
      hold_q <= next_hold;
      hrev_q <= next_hrev;
      mst_q  <= next_mst;
      dir_q  <= next_dir;
      mcnt_q <= next_mcnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flux-decay output shutoff.

  shut_t       sst_q, next_sst;
  logic [10:0] dcnt_q, next_dcnt;
  logic        fast_cut;

  assign fast_cut = !svc || pin_q.dip_restart || pin_q.tuning;

  always_comb begin
    next_sst  = sst_q;
    next_dcnt = dcnt_q;
    case (sst_q)
      S_ON: begin
        if (flux_sig) begin
          next_dcnt = 11'h0;
          next_sst  = (fast_cut || other_cut) ? S_CUT
                                              : S_DECAY;
        end
      end
      S_DECAY: begin
        if (other_cut || pin_q.dip_restart || pin_q.tuning) begin
          next_sst = S_CUT;
        end else if (!flux_sig) begin
          next_sst = S_ON;
        end else if (dcnt_q >= decay_lim) begin
          next_sst = S_CUT;
        end else if (tick) begin
          next_dcnt = dcnt_q + 11'h1;
        end
      end
      default: begin
        if (!flux_sig) begin
          next_sst = S_ON;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sst_q  <= S_ON;
      dcnt_q <= 11'h0;
    end else begin
      sst_q  <= next_sst;
      dcnt_q <= next_dcnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Drive outputs, registered from next state.

  drive_t drv_q, next_drv;

  // Decay keeps the gate on; only a cut, stop or fault drops it.
  always_comb begin
    next_drv.run_fwd  = next_mst == M_RUN && !next_dir;
    next_drv.run_rev  = next_mst == M_RUN && next_dir;
    next_drv.decel    = next_mst == M_DECEL;
    next_drv.coast    = next_mst == M_COAST;
    next_drv.decaying = next_sst == S_DECAY;
    next_drv.gate_on  = (next_mst == M_RUN || next_mst == M_DECEL)
                     && next_sst != S_CUT && !other_cut;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      drv_q <= '0;
    end else begin
      drv_q <= next_drv;
    end
  end

  assign stat = {24'h0, sst_q, mst_q, dir_q, hold_q, hold_en, drv_q.gate_on};

  assign run_forward       = drv_q.run_fwd;
  assign run_reverse       = drv_q.run_rev;
  assign decel_stop        = drv_q.decel;
  assign coast_stop        = drv_q.coast;
  assign output_gate_on    = drv_q.gate_on;
  assign flux_decay_active = drv_q.decaying;
  assign s_axi_awready     = awrdy_q;
  assign s_axi_wready      = wrdy_q;
  assign s_axi_bvalid      = bvalid_q;
  assign s_axi_bresp       = bresp_q;
  assign s_axi_arready     = arrdy_q;
  assign s_axi_rvalid      = rvalid_q;
  assign s_axi_rdata       = rdata_q;
  assign s_axi_rresp       = rresp_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence start_gone;
    mst_q == M_RUN && !cmd_on;
  endsequence

  sequence in_decay;
    sst_q == S_DECAY;
  endsequence

  decel_on_drop_a: assert property (
    start_gone and (sel == SEL_DECEL) |=> mst_q == M_DECEL
  ) else $error("start removal did not decelerate");

  // Only the entry into coasting is judged; a later change of the
  // setting must not turn an old coast into a failure.
  timed_coast_a: assert property (
    $rose(mst_q == M_COAST) |-> $past(timed)
  ) else $error("coast without timed stop setting");

  fwd_decode_a: assert property (
    !mode3 && pin_q.fwd && !pin_q.rev |=> mst_q == M_RUN && !dir_q
  ) else $error("forward input did not run forward");

  both_stop_a: assert property (
    start_gone and (!mode3 && pin_q.fwd == pin_q.rev)
    |=> mst_q == M_DECEL
  ) else $error("equal inputs did not decelerate");

  mode3_rev_a: assert property (
    mode3 && pin_q.fwd && pin_q.rev |=> mst_q == M_RUN && dir_q
  ) else $error("run and direction did not reverse");

  hold_keep_a: assert property (
    hold_q && hold_en && pin_q.out_stop |=> hold_q
  ) else $error("self-hold latch lost while enabled");

  stop_clear_a: assert property (
    !hold_en |=> !hold_q
  ) else $error("stop input did not clear latch");

  nosvc_cut_a: assert property (
    sst_q == S_ON && flux_sig && !svc |=> sst_q == S_CUT
  ) else $error("non-sensorless shutoff not immediate");

  decay_abort_a: assert property (
    in_decay and other_cut |=> sst_q == S_CUT ##1 !drv_q.gate_on
  ) else $error("decay not abandoned on other cause");

  decay_bound_a: assert property (
    in_decay |-> dcnt_q <= decay_lim
  ) else $error("flux decay ran past its limit");

  decay_volt_a: assert property (
    in_decay and (mst_q == M_RUN) |-> drv_q.gate_on
  ) else $error("output dropped during flux decay");

endmodule
`default_nettype wire

// file: test_motor_start_stop_control.sv
// Self-checking bench of the motor start/stop control block.
`default_nettype none
module test_motor_start_stop_control import motor_ss_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  pins_t       want = '0;
  wire pins_t  pins;
  wire drive_t d;
  logic [7:0]  s_axi_awaddr = '0;
  logic [7:0]  s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, brsp, rrsp;
  logic [31:0] s_axi_rdata, rdat;
  logic [31:0] rnd = 32'h53f6aa48;
  int          errors = 0;
  int          n_checks = 0;

  // A 4-cycle millisecond keeps the timed stops short.
  motor_start_stop_control #(.MS_CYC(4)) motor_start_stop_control_inst (
    .forward_start_input(pins.fwd), .reverse_start_input(pins.rev),
    .stop_terminal(pins.stop_term), .jog_input(pins.jog),
    .output_stop_input(pins.out_stop), .gp_terminal(pins.gp),
    .fault_input(pins.fault), .dip_restart_input(pins.dip_restart),
    .online_tuning_input(pins.tuning), .run_forward(d.run_fwd),
    .run_reverse(d.run_rev), .decel_stop(d.decel), .coast_stop(d.coast),
    .output_gate_on(d.gate_on), .flux_decay_active(d.decaying), .*);
  cmd_panel cmd_panel_inst (.core_clk(core_clk), .want(want),
    .pins(pins), .output_contactor());

  // Free-running core clock.
  always #10 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////
  // Stimulus source and expectations.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected {forward, reverse} run from the two start inputs.
  function automatic logic [1:0] exp_dir(input logic rd, f, r);
    if (rd)
      return {f & !r, f & r};
    return {f & !r, r & !f};
  endfunction

  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus master: valids drop as each channel is taken, ready held to answer.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    brsp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    tk(12);
    reset <= 1'b0;
    rd(ADDR_CTRL);
    chk("ctrl", CTRL_RESET, rdat);
    rd(ADDR_TERM);
    chk("term", TERM_RESET, rdat);
    rd(8'h0c);
    chk("rresp", RESP_DECERR, rrsp);
    wr(8'h10, 32'h0);
    chk("bresp", RESP_DECERR, brsp);
    // Random start inputs in both decoding modes, from a stop each time.
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      want <= '0;
      wr(ADDR_CTRL, {16'h0, rnd[2] ? SEL_RUNDIR : SEL_DECEL});
      want.fwd <= rnd[0];
      want.rev <= rnd[1];
      tk(8);
      chk("dir", exp_dir(rnd[2], rnd[0], rnd[1]), {d.run_fwd, d.run_rev});
    end
    want <= '0;
    wr(ADDR_CTRL, CTRL_RESET);
    want.fwd <= 1'b1;
    tk(8);
    want.rev <= 1'b1;
    tk(8);
    chk("both_on", 1'b1, d.decel);
    want <= '0;
    tk(8);
    want.fwd <= 1'b1;
    tk(8);
    want.fwd <= 1'b0;
    tk(8);
    chk("decel", 2'b10, {d.decel, d.coast});
    // One second of timed coast, set directly and with the 1000 offset.
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL, k ? 32'h3e9 : 32'h1);
      want.fwd <= 1'b1;
      tk(8);
      want.fwd <= 1'b0;
      tk(3990);
      chk("coast_early", 1'b0, d.coast);
      tk(30);
      chk("coast", 1'b1, d.coast);
    end
    // Self-hold: pulses latch, output stop keeps it, stop input clears it.
    wr(ADDR_CTRL, CTRL_RESET);
    want.stop_term <= 1'b1;
    want.rev <= 1'b1;
    tk(8);
    want.rev <= 1'b0;
    tk(8);
    chk("held_rev", 1'b1, d.run_rev);
    want.fwd <= 1'b1;
    tk(8);
    want.fwd <= 1'b0;
    tk(8);
    chk("held_fwd", 2'b10, {d.run_fwd, d.run_rev});
    want.out_stop <= 1'b1;
    tk(8);
    chk("gate_off", 1'b0, d.gate_on);
    rd(ADDR_STAT);
    chk("latch", 1'b1, rdat[2]);
    want.out_stop <= 1'b0;
    want.stop_term <= 1'b0;
    tk(8);
    chk("unhold", 3'b001, {d.run_fwd, d.run_rev, d.decel});
    want.fwd <= 1'b1;
    tk(8);
    want.fwd <= 1'b0;
    tk(8);
    chk("no_hold", 1'b0, d.run_fwd);
    // Jog masks the stop input; code 25 moves it to a general terminal.
    wr(ADDR_CTRL, CTRL_RESET | 32'h100000);
    want.stop_term <= 1'b1;
    want.jog <= 1'b1;
    tk(8);
    rd(ADDR_STAT);
    chk("jog_hold", 1'b0, rdat[1]);
    want.jog <= 1'b0;
    wr(ADDR_TERM, {24'h0, FN_STOP});
    tk(8);
    rd(ADDR_STAT);
    chk("gp_stop_off", 1'b0, rdat[1]);
    want.gp[0] <= 1'b1;
    tk(8);
    rd(ADDR_STAT);
    chk("gp_stop_on", 1'b1, rdat[1]);
    // Flux decay shutoff on terminal 1, sensorless control, class 0.
    want <= '0;
    wr(ADDR_TERM, {16'h0, FN_FLUX, 8'h0});
    wr(ADDR_CTRL, CTRL_RESET | 32'h10000);
    want.fwd <= 1'b1;
    tk(8);
    want.gp[1] <= 1'b1;
    tk(8);
    chk("decay", 2'b11, {d.gate_on, d.decaying});
    tk(1000);
    chk("decay_cut", 2'b00, {d.gate_on, d.decaying});
    // Class 1 (500 ms) must still decay at 1990 cycles and be cut 30 cycles later.
    want.gp[1] <= 1'b0;
    tk(8);
    wr(ADDR_CTRL, CTRL_RESET | 32'h30000);
    want.gp[1] <= 1'b1;
    tk(1990);
    chk("decay_c1", 2'b11, {d.gate_on, d.decaying});
    tk(30);
    chk("cut_c1", 2'b00, {d.gate_on, d.decaying});
    // Immediate cuts: fault in decay, tuning, dip restart, other control.
    for (int k = 0; k < 4; k++) begin
      want.gp[1] <= 1'b0;
      tk(8);
      if (k == 3) wr(ADDR_CTRL, CTRL_RESET);
      want.tuning <= (k == 1);
      want.dip_restart <= (k == 2);
      want.gp[1] <= 1'b1;
      tk(8);
      if (k == 0) want.fault <= 1'b1;
      tk(8);
      chk("cut", 2'b00, {d.gate_on, d.decaying});
      want.fault <= 1'b0;
    end
    end_sim;
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #(20 * 40000);
    errors++;
    end_sim;
  end
endmodule
`default_nettype wire
